//--- pkg/cocr_map.svh
`ifndef COCR_MAP_SVH
`define COCR_MAP_SVH

// Command codes of the two option registers.
`define COCR_SMB_OPT_A     8'h12
`define COCR_SMB_OPT_B     8'h3B
`define COCR_I2C_OPT_A_LO  8'h00
`define COCR_I2C_OPT_A_HI  8'h01
`define COCR_I2C_OPT_B_LO  8'h02
`define COCR_I2C_OPT_B_HI  8'h03

// Field positions, option register A.
`define COCR_A_IN_GAIN     4
`define COCR_A_DIS_GAIN    3
`define COCR_A_RSVD_ONE    2
`define COCR_A_IREG_EN     1
`define COCR_A_INHIBIT     0

// Field positions, option register B.
`define COCR_B_RATIO       12
`define COCR_B_BATMON_EN   11
`define COCR_B_PWRMON_EN   10
`define COCR_B_PWR_GAIN    9
`define COCR_B_COMP_REF    7

// Writable masks, fixed read values and reset values.
`define COCR_A_WMASK       16'h001B
`define COCR_A_FIXED       16'h0004
`define COCR_A_RESET       16'h000A
`define COCR_B_WMASK       16'h1E80
`define COCR_B_FIXED       16'h0000
`define COCR_B_RESET       16'h0200

// Byte lanes of a two-byte register.
`define COCR_LANE_LO       16'h00FF
`define COCR_LANE_HI       16'hFF00
`define COCR_LANE_ALL      16'hFFFF

`endif

//--- pkg/cocr_pkg.sv
package cocr_pkg;

  // One decoded command from the serial front end.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        i2c;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } cocr_req_t;

  // Answer, one cycle after the command.
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [15:0] rdata;
  } cocr_rsp_t;

  // Control levels toward the analog circuits.
  typedef struct packed {
    logic input_monitor_gain_80x;
    logic discharge_monitor_gain_16x;
    logic input_current_regulation_en;
    logic charge_inhibit;
    logic sense_resistor_ratio_2to1;
    logic battery_current_monitor_en;
    logic system_power_monitor_en;
    logic power_monitor_gain_1uaw;
    logic comparator_reference_1v2;
  } cocr_cfg_t;

endpackage

//--- design/cocr_regs.sv
// Function
// - Bit 4 of option register A picks 40x input current monitor gain at 0, 80x at 1, and resets to 0.
// - Bit 3 of option register A picks 8x discharge monitor gain at 0, 16x at 1, and resets to 1.
// - Bit 1 of option register A enables the input current regulation loop at 1 and resets to 1.
// - Bit 0 of option register A inhibits charging at 1, permits it at 0, and resets to 0.
// - Bit 12 of option register B sets the sense resistor ratio to 1:1 at 0 (reset) or 2:1 at 1.
// - Bit 11 of option register B turns the battery current monitor buffer on at 1, off at 0, reset 0.
// - Bit 10 of option register B turns the system power monitor and its buffer on at 1, reset 0.
// - Bit 9 of option register B picks power monitor gain 0.25 uA/W at 0 or 1 uA/W at 1, reset 1.
// - Bit 7 of option register B picks comparator reference 2.3 V at 0 (reset) or 1.2 V at 1.
// - Bits 15 to 13 and bit 8 of option register B are read-only and read 0.
// - Option register B is SMBus code 0x3B, 16 bits, or I2C bytes 03H high and 02H low.
`timescale 1ns/10ps
`default_nettype none
`include "cocr_map.svh"

module cocr_regs
  import cocr_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire cocr_req_t req,
  output var  cocr_rsp_t rsp,
  output var  cocr_cfg_t cfg,
  output logic           charge_permit
);

  logic [15:0] opt_a_q;
  logic [15:0] opt_a_d;
  logic [15:0] opt_b_q;
  logic [15:0] opt_b_d;
  cocr_rsp_t   rsp_q;
  cocr_rsp_t   rsp_d;
  logic [15:0] view_a;
  logic [15:0] view_b;

  // Only writable bits are stored; fixed bits are merged in on every read.
  assign view_a = (opt_a_q & `COCR_A_WMASK) | `COCR_A_FIXED;
  assign view_b = (opt_b_q & `COCR_B_WMASK) | `COCR_B_FIXED;

  always_comb begin
    logic        sel_a;
    logic        sel_b;
    logic        hi;
    logic [15:0] lane;
    logic [15:0] wdat;
    sel_a   = 1'b0;
    sel_b   = 1'b0;
    hi      = 1'b0;
    lane    = `COCR_LANE_ALL;
    wdat    = req.wdata;
    opt_a_d = opt_a_q;
    opt_b_d = opt_b_q;
    rsp_d   = '0;
    if (req.i2c) begin
      // A byte bus reaches each half of a register on its own address.
      unique case (req.addr)
        `COCR_I2C_OPT_A_LO: sel_a = 1'b1;
        `COCR_I2C_OPT_A_HI: begin
          sel_a = 1'b1;
          hi    = 1'b1;
        end
        `COCR_I2C_OPT_B_LO: sel_b = 1'b1;
        `COCR_I2C_OPT_B_HI: begin
          sel_b = 1'b1;
          hi    = 1'b1;
        end
        default: ;
      endcase
      lane = hi ? `COCR_LANE_HI : `COCR_LANE_LO;
      wdat = {req.wdata[7:0], req.wdata[7:0]};
    end else begin
      sel_a = (req.addr == `COCR_SMB_OPT_A);
      sel_b = (req.addr == `COCR_SMB_OPT_B);
    end
    if (req.valid) begin
      rsp_d.valid = 1'b1;
      rsp_d.hit   = sel_a | sel_b;
      if (req.write) begin
        // Reserved positions are masked out of the stored value.
        if (sel_a) begin
          opt_a_d = (opt_a_q & ~(lane & `COCR_A_WMASK)) | (wdat & lane & `COCR_A_WMASK);
        end
        if (sel_b) begin
          opt_b_d = (opt_b_q & ~(lane & `COCR_B_WMASK)) | (wdat & lane & `COCR_B_WMASK);
        end
      end else if (req.i2c) begin
        if (sel_a) begin
          rsp_d.rdata = {8'h00, hi ? view_a[15:8] : view_a[7:0]};
        end
        if (sel_b) begin
          rsp_d.rdata = {8'h00, hi ? view_b[15:8] : view_b[7:0]};
        end
      end else begin
        if (sel_a) begin
          rsp_d.rdata = view_a;
        end
        if (sel_b) begin
          rsp_d.rdata = view_b;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opt_a_q <= `COCR_A_RESET;
      opt_b_q <= `COCR_B_RESET;
      rsp_q   <= '0;
    end else begin
      opt_a_q <= opt_a_d;
      opt_b_q <= opt_b_d;
      rsp_q   <= rsp_d;
    end
  end

  assign rsp = rsp_q;

  always_comb begin
    cfg                             = '0;
    cfg.input_monitor_gain_80x      = opt_a_q[`COCR_A_IN_GAIN];
    cfg.discharge_monitor_gain_16x  = opt_a_q[`COCR_A_DIS_GAIN];
    cfg.input_current_regulation_en = opt_a_q[`COCR_A_IREG_EN];
    cfg.charge_inhibit              = opt_a_q[`COCR_A_INHIBIT];
    cfg.sense_resistor_ratio_2to1   = opt_b_q[`COCR_B_RATIO];
    cfg.battery_current_monitor_en  = opt_b_q[`COCR_B_BATMON_EN];
    cfg.system_power_monitor_en     = opt_b_q[`COCR_B_PWRMON_EN];
    cfg.power_monitor_gain_1uaw     = opt_b_q[`COCR_B_PWR_GAIN];
    cfg.comparator_reference_1v2    = opt_b_q[`COCR_B_COMP_REF];
  end

  // The charge current path acts whenever the inhibit bit is 0, which it is from reset.
  assign charge_permit = ~opt_a_q[`COCR_A_INHIBIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic smb_wr_a;
  logic smb_wr_b;
  assign smb_wr_a = req.valid && req.write && !req.i2c && req.addr == `COCR_SMB_OPT_A;
  assign smb_wr_b = req.valid && req.write && !req.i2c && req.addr == `COCR_SMB_OPT_B;
  logic smb_miss;
  assign smb_miss = req.valid && !req.i2c && req.addr != `COCR_SMB_OPT_A && req.addr != `COCR_SMB_OPT_B;

  a_in_gain_write: assert property (smb_wr_a |=> cfg.input_monitor_gain_80x == $past(req.wdata[4]))
    else $error("input monitor gain did not follow write");
  a_dis_gain_write: assert property (smb_wr_a |=> cfg.discharge_monitor_gain_16x == $past(req.wdata[3]))
    else $error("discharge monitor gain did not follow write");
  a_ireg_en_write: assert property (smb_wr_a |=> cfg.input_current_regulation_en == $past(req.wdata[1]))
    else $error("regulation enable did not follow write");
  a_inhibit_permit: assert property (smb_wr_a |=> charge_permit == !$past(req.wdata[0]))
    else $error("charge permit disagrees with inhibit write");
  a_ratio_write: assert property (smb_wr_b |=> cfg.sense_resistor_ratio_2to1 == $past(req.wdata[12]))
    else $error("sense ratio did not follow write");
  a_batmon_write: assert property (smb_wr_b |=> cfg.battery_current_monitor_en == $past(req.wdata[11]))
    else $error("battery monitor enable did not follow write");
  a_pwrmon_write: assert property (smb_wr_b |=> cfg.system_power_monitor_en == $past(req.wdata[10]))
    else $error("power monitor enable did not follow write");
  a_pwr_gain_write: assert property (smb_wr_b |=> cfg.power_monitor_gain_1uaw == $past(req.wdata[9]))
    else $error("power monitor gain did not follow write");
  a_comparator_reference_write: assert property (smb_wr_b |=> cfg.comparator_reference_1v2 == $past(req.wdata[7]))
    else $error("comparator reference did not follow write");
  a_b_rsvd_zero: assert property (req.valid && !req.write && !req.i2c && req.addr == `COCR_SMB_OPT_B
                                  |=> rsp.valid && rsp.hit && rsp.rdata[15:13] == 3'h0 && !rsp.rdata[8])
    else $error("reserved bits of register B read non-zero");
  a_i2c_hi_only: assert property (req.valid && req.write && req.i2c && req.addr == `COCR_I2C_OPT_B_HI
                                  |=> view_b[7:0] == $past(view_b[7:0]) && view_b[12] == $past(req.wdata[4]))
    else $error("I2C high byte write misplaced");
  a_i2c_lo_only: assert property (req.valid && req.write && req.i2c && req.addr == `COCR_I2C_OPT_B_LO
                                  |=> view_b[15:8] == $past(view_b[15:8]) && view_b[7] == $past(req.wdata[7]))
    else $error("I2C low byte write misplaced");
  a_a_rsvd_fixed: assert property (smb_wr_a |=> view_a[2] && view_a[15:5] == 11'h000)
    else $error("reserved bits of register A changed");
  a_b_rsvd_store: assert property (smb_wr_b |=> (opt_b_q & ~`COCR_B_WMASK) == 16'h0000)
    else $error("reserved bits of register B were stored");
  a_cfg_holds: assert property (!(req.valid && req.write) |=> $stable(cfg) && $stable(charge_permit))
    else $error("control levels moved without a write");

  // Checked at the first edge after release, so a request taken at that edge cannot mask a wrong reset value.
  a_reset_in_gain: assert property ($rose(rst_b) |-> !cfg.input_monitor_gain_80x)
    else $error("input monitor gain not at 40x after reset");
  a_reset_dis_gain: assert property ($rose(rst_b) |-> cfg.discharge_monitor_gain_16x)
    else $error("discharge monitor gain not at 16x after reset");
  a_reset_ireg_en: assert property ($rose(rst_b) |-> cfg.input_current_regulation_en)
    else $error("regulation loop not enabled after reset");
  a_reset_permit: assert property ($rose(rst_b) |-> !cfg.charge_inhibit && charge_permit)
    else $error("charging inhibited after reset");
  a_reset_ratio: assert property ($rose(rst_b) |-> !cfg.sense_resistor_ratio_2to1)
    else $error("sense ratio not 1:1 after reset");
  a_reset_batmon: assert property ($rose(rst_b) |-> !cfg.battery_current_monitor_en)
    else $error("battery monitor buffer on after reset");
  a_reset_pwrmon: assert property ($rose(rst_b) |-> !cfg.system_power_monitor_en)
    else $error("power monitor on after reset");
  a_reset_pwr_gain: assert property ($rose(rst_b) |-> cfg.power_monitor_gain_1uaw)
    else $error("power monitor gain not high after reset");
  a_reset_comparator_reference: assert property ($rose(rst_b) |-> !cfg.comparator_reference_1v2)
    else $error("comparator reference not 2.3 V after reset");

  // The host pairs answers to commands by timing alone, so the answer must never slip or repeat.
  a_rsp_follows_req: assert property (req.valid |=> rsp.valid)
    else $error("command got no answer in the next cycle");
  a_rsp_idle_quiet: assert property (!req.valid |=> !rsp.valid)
    else $error("answer without a command");
  a_miss_reads_zero: assert property (smb_miss |=> !rsp.hit && rsp.rdata == 16'h0000)
    else $error("unmapped command answered as a hit");
  a_miss_no_write: assert property (smb_miss && req.write |=> $stable(opt_a_q) && $stable(opt_b_q))
    else $error("unmapped write changed a register");
  a_write_rdata_zero: assert property (req.valid && req.write |=> rsp.rdata == 16'h0000)
    else $error("write answer carried data");
  a_i2c_rd_hi_zero: assert property (req.valid && !req.write && req.i2c |=> rsp.rdata[15:8] == 8'h00)
    else $error("I2C read returned a non-zero upper byte");

  c_smb_write_b: cover property (smb_wr_b ##1 req.valid && !req.write);
  c_i2c_read_a: cover property (req.valid && !req.write && req.i2c && req.addr == `COCR_I2C_OPT_A_LO);
  c_unmapped: cover property (req.valid ##1 rsp.valid && !rsp.hit);
  c_i2c_write_b_hi: cover property (req.valid && req.write && req.i2c && req.addr == `COCR_I2C_OPT_B_HI);
  c_miss_write: cover property (smb_miss && req.write);

endmodule  // cocr_regs
`default_nettype wire

//--- tb/cocr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cocr_host_model
  import cocr_pkg::*;
(
  input  wire logic      clk,
  output var  cocr_req_t req,
  input  wire cocr_rsp_t rsp
);
  cocr_rsp_t got;
  initial req = '0;
  task automatic cmd(input logic w, input logic i2c, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    req = '{1'b1, w, i2c, a, d};
    @(posedge clk);
    #1;
    got = rsp;
    // Released lines carry the inverse so a stale value never looks held.
    req = '{1'b0, ~w, ~i2c, ~a, ~d};
  endtask
  task automatic start_charge(input logic [15:0] amps);
    cmd(1'b1, 1'b0, 8'h12, 16'h0000);
    cmd(1'b1, 1'b0, 8'h14, amps);
  endtask
endmodule // cocr_host_model
`default_nettype wire

//--- tb/tb_charger_option_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_charger_option_config_regs
  import cocr_pkg::*;
;
  logic        clk;
  logic        rst_b;
  cocr_req_t   req;
  cocr_rsp_t   rsp;
  cocr_cfg_t   cfg;
  logic        permit;
  int          failures;
  int          n_checks;
  logic [40:0] r;
  // Columns: byte mode, address, write data, value read back afterwards.
  logic [40:0] rows [8] = '{
    {1'b0, 8'h12, 16'hFFFF, 16'h001F}, {1'b0, 8'h12, 16'h0000, 16'h0004},
    {1'b0, 8'h3B, 16'hFFFF, 16'h1E80}, {1'b0, 8'h3B, 16'h0000, 16'h0000},
    {1'b1, 8'h03, 16'h00FF, 16'h001E}, {1'b1, 8'h02, 16'h00FF, 16'h0080},
    {1'b1, 8'h00, 16'h00FF, 16'h001F}, {1'b1, 8'h01, 16'h00FF, 16'h0000}};

  cocr_regs uut (.clk(clk), .rst_b(rst_b), .req(req), .rsp(rsp), .cfg(cfg), .charge_permit(permit));
  cocr_host_model host (.clk(clk), .req(req), .rsp(rsp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic i2c, input logic [7:0] a, input logic [15:0] exp);
    host.cmd(1'b0, i2c, a, 16'h0000);
    chk("valid", {15'h0, host.got.valid}, 16'h0001);
    chk("read", host.got.rdata, exp);
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    n_checks = 0;
    do_reset();
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      host.cmd(1'b1, r[40], r[39:32], r[31:16]);
      chk("hit", {15'h0, host.got.hit}, 16'h0001);
      chk("wr_rdata", host.got.rdata, 16'h0000);
      rd(r[40], r[39:32], r[15:0]);
    end
    chk("cfg", {7'h00, cfg}, 16'h01FF);
    rd(1'b0, 8'h3B, 16'h1E80);
    chk("permit", {15'h0, permit}, 16'h0000);
    $display("table test done");
    do_reset();
    chk("cfg", {7'h00, cfg}, 16'h00C2);
    chk("permit", {15'h0, permit}, 16'h0001);
    rd(1'b0, 8'h12, 16'h000E);
    rd(1'b0, 8'h3B, 16'h0200);
    $display("reset test done");
    host.start_charge(16'h1000);
    chk("miss", {15'h0, host.got.hit}, 16'h0000);
    chk("missdata", host.got.rdata, 16'h0000);
    rd(1'b0, 8'h12, 16'h0004);
    rd(1'b0, 8'h3B, 16'h0200);
    $display("unmapped test done");
    test_done();
  end
endmodule // tb_charger_option_config_regs
`default_nettype wire
